// [rtl/fhs_sequencer.sv]
// Find home sequencer: ordered homing phases with retry and fault report
// Contract
// - Phase 1 frees gripper fingers before carriage travel; fault 40.
// - Phase 2 clears room for a flip; carriage fault 44.
// - Phase 3 retracts fingers to mechanical stop; fault 45.
// - Phase 4 drives carriage to drive-end stop; fault 46.
// - Phase 5 translates gripper to non-leadscrew side; fault 47.
// - Phase 6 confirms home by sensor; fault 41, or 61 for sensor.
// - Phase 7 retracts fingers to stop again; fault 45.
// - Phase 8 translates to leadscrew side, carriage far; fault 48.
// - Phase 9 detects held cartridge by plunging fingers; fault 4D.
// - Phase 10 finds orientation; faults 4A motion, 4C flip, 60 sensor.
// - Phase 11 calibrates on leadscrew sensor twice; 48, 4C, 60.
// - Phase 12 calibrates on other sensor twice; 49, 4C, 61.
// - Phase 13 translates non-leadscrew side, carriage far; fault 49.
// - Phase 14 steps toward drives and flips if misoriented; fault 4C.
// - Repeat whole list until clean pass or four failures total.
// - On four failures stop, name three units, report hardware error.
// - Retry limit setting 1 runs each phase once, no recovery.
// - Motions may run at half or quarter speed by speed setting.
// - Faults go out as motion-step codes, never to operator panel.
// - Every fault code is a hexadecimal value.
// - No assumed start state; on completion start calibration routine.
`timescale 1ns/1ns
`default_nettype none
module fhs_sequencer
    import fhs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Control
    input wire logic start,
    input wire logic [3:0] retry_limit_setting,
    input wire logic [1:0] speed_setting,
    input wire logic need_flip,
    // Motor subsystem command
    output logic cmd_valid,
    output logic [3:0] cmd_phase,
    output logic cmd_face,
    output logic [1:0] cmd_speed,
    // Motor subsystem answer
    input wire logic mot_done,
    input wire logic mot_fault,
    input wire logic [1:0] mot_fault_kind,
    // Fault report
    output logic fault_valid,
    output logic [7:0] fault_code,
    output logic [2:0] fail_count,
    // Completion
    output logic busy,
    output logic home_ok,
    output logic calib_start,
    output logic hw_error,
    output logic [7:0] hw_error_code,
    output logic [23:0] fru_list
);
    // ************************************************************
    // Fault code selection
    // ************************************************************
    function automatic logic [7:0] code_for(input logic [3:0] ph, input logic [1:0] kind);
        logic [7:0] c;
        c = FLT_FINGER_FREE;
        case (ph)
            4'h1: c = FLT_FINGER_FREE;
            4'h2: c = FLT_CLEARANCE;
            4'h3: c = FLT_FINGER_STOP;
            4'h4: c = FLT_CARR_INIT;
            4'h5: c = FLT_XLATE_NLS;
            4'h6: c = (kind == KIND_SENSOR) ? FLT_SENS_NLS : FLT_HOME_VERIFY;
            4'h7: c = FLT_FINGER_STOP;
            4'h8: c = FLT_CARR_LS;
            4'h9: c = FLT_CART_DET;
            4'ha: c = (kind == KIND_SENSOR) ? FLT_SENS_LS :
                      (kind == KIND_FLIP) ? FLT_FLIP : FLT_ORIENT;
            4'hb: c = (kind == KIND_SENSOR) ? FLT_SENS_LS :
                      (kind == KIND_FLIP) ? FLT_FLIP : FLT_CARR_LS;
            4'hc: c = (kind == KIND_SENSOR) ? FLT_SENS_NLS :
                      (kind == KIND_FLIP) ? FLT_FLIP : FLT_CARR_NLS;
            4'hd: c = FLT_CARR_NLS;
            4'he: c = FLT_FLIP;
            default: c = FLT_FINGER_FREE;
        endcase
        return c;
    endfunction

    // ************************************************************
    // Sequencer state
    // ************************************************************
    fhs_state_t state_r, state_nxt;
    logic [3:0] phase_r, phase_nxt;
    logic face_r, face_nxt;
    logic [2:0] fails_r, fails_nxt;
    logic [7:0] fcode_r, fcode_nxt;
    logic fvalid_r, fvalid_nxt;
    logic [1:0] speed_r, speed_nxt;
    logic once_r, once_nxt;
    logic [7:0] last_r [FRU_COUNT];
    logic [7:0] last_nxt [FRU_COUNT];
    logic [7:0] hwc_r, hwc_nxt;
    logic is_last;

    // Last phase of the ordered list
    assign is_last = (phase_r == PH_LAST);

    // Next state of the sequencer
    always_comb begin
        state_nxt = state_r;
        phase_nxt = phase_r;
        face_nxt = face_r;
        fails_nxt = fails_r;
        fcode_nxt = fcode_r;
        fvalid_nxt = 1'b0;
        speed_nxt = speed_r;
        once_nxt = once_r;
        last_nxt = last_r;
        hwc_nxt = hwc_r;
        case (state_r)
            ST_IDLE, ST_DONE, ST_HALT: begin
                if (start) begin
                    // Nothing assumed about the mechanism; always from phase 1
                    state_nxt = ST_ISSUE;
                    phase_nxt = PH_FIRST;
                    face_nxt = 1'b0;
                    fails_nxt = 3'h0;
                    speed_nxt = speed_setting;
                    once_nxt = (retry_limit_setting == 4'h1);
                    hwc_nxt = 8'h00;
                end
            end
            ST_ISSUE: begin
                state_nxt = ST_WAIT;
            end
            ST_WAIT: begin
                if (mot_fault) begin
                    fcode_nxt = code_for(phase_r, mot_fault_kind);
                    fvalid_nxt = 1'b1;
                    fails_nxt = fails_r + 3'h1;
                    last_nxt[2] = last_r[1];
                    last_nxt[1] = last_r[0];
                    last_nxt[0] = code_for(phase_r, mot_fault_kind);
                    if (once_r) begin
                        state_nxt = ST_HALT;
                    end else if (fails_r == 3'(FAIL_LIMIT - 1)) begin
                        state_nxt = ST_HALT;
                        hwc_nxt = HW_ERR_CODE;
                    end else begin
                        state_nxt = ST_ISSUE;
                        phase_nxt = PH_FIRST;
                        face_nxt = 1'b0;
                    end
                end else if (mot_done) begin
                    if ((phase_r == 4'hb || phase_r == 4'hc) && !face_r) begin
                        face_nxt = 1'b1;
                        state_nxt = ST_ISSUE;
                    end else if (is_last) begin
                        state_nxt = ST_CALIB;
                    end else begin
                        face_nxt = 1'b0;
                        phase_nxt = phase_r + 4'h1;
                        // Skip the final flip when already facing the arm
                        if (phase_r == 4'hd && !need_flip) begin
                            state_nxt = ST_CALIB;
                        end else begin
                            state_nxt = ST_ISSUE;
                        end
                    end
                end
            end
            ST_CALIB: begin
                state_nxt = ST_DONE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Register the sequencer state
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            phase_r <= 4'h0;
            face_r <= 1'b0;
            fails_r <= 3'h0;
            fcode_r <= 8'h00;
            fvalid_r <= 1'b0;
            speed_r <= SPD_FULL;
            once_r <= 1'b0;
            last_r <= '{default: 8'h00};
            hwc_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            face_r <= face_nxt;
            fails_r <= fails_nxt;
            fcode_r <= fcode_nxt;
            fvalid_r <= fvalid_nxt;
            speed_r <= speed_nxt;
            once_r <= once_nxt;
            last_r <= last_nxt;
            hwc_r <= hwc_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Command is one pulse per phase attempt
    assign cmd_valid = (state_r == ST_ISSUE);
    assign cmd_phase = phase_r;
    assign cmd_face = face_r;
    assign cmd_speed = speed_r;
    assign fault_valid = fvalid_r;
    assign fault_code = fcode_r;
    assign fail_count = fails_r;
    assign busy = (state_r == ST_ISSUE) || (state_r == ST_WAIT);
    assign home_ok = (state_r == ST_DONE);
    assign calib_start = (state_r == ST_CALIB);
    assign hw_error = (state_r == ST_HALT) && (fails_r == 3'(FAIL_LIMIT));
    assign hw_error_code = hwc_r;
    // Three suspect units, most recent fault first
    assign fru_list = {last_r[0], last_r[1], last_r[2]};

    // ************************************************************
    // Checks
    // ************************************************************
    // A fault answer taken while waiting
    sequence s_fault_seen;
        state_r == ST_WAIT && mot_fault;
    endsequence

    // A success answer taken while waiting
    sequence s_done_seen;
        state_r == ST_WAIT && mot_done && !mot_fault;
    endsequence

    // A start request taken while not busy
    sequence s_start_taken;
        (state_r == ST_IDLE || state_r == ST_DONE || state_r == ST_HALT) && start;
    endsequence

    // One command, then silence until the answer
    a_cmd_waits: assert property (@(posedge mclk) disable iff (!nrst)
        cmd_valid |=> !cmd_valid)
        else $error("command issued twice without an answer");
    // Each pass opens on phase one at the latched speed
    a_start_first: assert property (@(posedge mclk) disable iff (!nrst)
        s_start_taken
        |=> cmd_valid && cmd_phase == PH_FIRST && cmd_speed == $past(speed_setting))
        else $error("pass did not open on phase one");
    // Every fault is counted and reported once
    a_fault_count: assert property (@(posedge mclk) disable iff (!nrst)
        s_fault_seen |=> fault_valid && fail_count == $past(fail_count) + 3'h1)
        else $error("fault not counted");
    // Phase one fault code
    a_phase_one_code: assert property (@(posedge mclk) disable iff (!nrst)
        s_fault_seen and (phase_r == 4'h1) |=> fault_valid && fault_code == FLT_FINGER_FREE)
        else $error("phase one fault code wrong");
    // Clearance phase fault code
    a_clear_code: assert property (@(posedge mclk) disable iff (!nrst)
        s_fault_seen and (phase_r == 4'h2) |=> fault_code == FLT_CLEARANCE)
        else $error("clearance fault code wrong");
    // Home sensor fault code
    a_home_sensor: assert property (@(posedge mclk) disable iff (!nrst)
        s_fault_seen and (phase_r == 4'h6 && mot_fault_kind == KIND_SENSOR)
        |=> fault_code == FLT_SENS_NLS)
        else $error("home sensor fault code wrong");
    // Cartridge check fault code
    a_cart_code: assert property (@(posedge mclk) disable iff (!nrst)
        s_fault_seen and (phase_r == 4'h9) |=> fault_code == FLT_CART_DET)
        else $error("cartridge check fault code wrong");
    // Orientation flip fault code
    a_orient_flip: assert property (@(posedge mclk) disable iff (!nrst)
        s_fault_seen and (phase_r == 4'ha && mot_fault_kind == KIND_FLIP)
        |=> fault_code == FLT_FLIP)
        else $error("orientation flip code wrong");
    // Leadscrew side sensor fault code
    a_ls_sensor: assert property (@(posedge mclk) disable iff (!nrst)
        s_fault_seen and (phase_r == 4'hb && mot_fault_kind == KIND_SENSOR)
        |=> fault_code == FLT_SENS_LS)
        else $error("leadscrew sensor fault code wrong");
    // Far side carriage fault code
    a_nls_carriage: assert property (@(posedge mclk) disable iff (!nrst)
        s_fault_seen and (phase_r == 4'hc && mot_fault_kind == KIND_MOTION)
        |=> fault_code == FLT_CARR_NLS)
        else $error("far side carriage fault code wrong");
    // Retry restarts the list from phase one
    a_retry_restart: assert property (@(posedge mclk) disable iff (!nrst)
        s_fault_seen and (!once_r && fails_r < 3'(FAIL_LIMIT - 1))
        |=> state_r == ST_ISSUE && phase_r == PH_FIRST)
        else $error("retry did not restart from phase one");
    // Fourth failure halts with the hardware error
    a_limit_halt: assert property (@(posedge mclk) disable iff (!nrst)
        s_fault_seen and (!once_r && fails_r == 3'(FAIL_LIMIT - 1))
        |=> hw_error && hw_error_code == HW_ERR_CODE)
        else $error("failure limit did not halt");
    // Newest fault heads the suspect list
    a_fru_newest: assert property (@(posedge mclk) disable iff (!nrst)
        s_fault_seen |=> fru_list[23:16] == fault_code)
        else $error("newest fault not first suspect");
    // Single run halts on its first fault
    a_single_run: assert property (@(posedge mclk) disable iff (!nrst)
        s_fault_seen and once_r |=> state_r == ST_HALT ##1 !cmd_valid)
        else $error("single run entered recovery");
    // Second face of a calibration phase
    a_face_twice: assert property (@(posedge mclk) disable iff (!nrst)
        s_done_seen and (phase_r == 4'hb && !face_r)
        |=> cmd_valid && cmd_phase == 4'hb && cmd_face)
        else $error("second face not calibrated");
    // A gripper facing the arm skips the final flip
    a_skip_flip: assert property (@(posedge mclk) disable iff (!nrst)
        s_done_seen and (phase_r == 4'hd && !need_flip) |=> calib_start)
        else $error("final flip not skipped");
    // Calibration start is followed by completion
    a_calib_follows: assert property (@(posedge mclk) disable iff (!nrst)
        calib_start |=> home_ok)
        else $error("calibration start not followed by completion");
endmodule
`default_nettype wire

// [rtl/fhs_pkg.sv]
// Package with constants and types for the find home sequencer
`default_nettype none
package fhs_pkg;
    // Fault codes, hexadecimal
    localparam logic [7:0] FLT_FINGER_FREE = 8'h40;
    localparam logic [7:0] FLT_HOME_VERIFY = 8'h41;
    localparam logic [7:0] FLT_CLEARANCE = 8'h44;
    localparam logic [7:0] FLT_FINGER_STOP = 8'h45;
    localparam logic [7:0] FLT_CARR_INIT = 8'h46;
    localparam logic [7:0] FLT_XLATE_NLS = 8'h47;
    localparam logic [7:0] FLT_CARR_LS = 8'h48;
    localparam logic [7:0] FLT_CARR_NLS = 8'h49;
    localparam logic [7:0] FLT_ORIENT = 8'h4a;
    localparam logic [7:0] FLT_FLIP = 8'h4c;
    localparam logic [7:0] FLT_CART_DET = 8'h4d;
    localparam logic [7:0] FLT_SENS_LS = 8'h60;
    localparam logic [7:0] FLT_SENS_NLS = 8'h61;
    // Fault kinds reported by the motor subsystem
    localparam logic [1:0] KIND_MOTION = 2'h0;
    localparam logic [1:0] KIND_FLIP = 2'h1;
    localparam logic [1:0] KIND_SENSOR = 2'h2;
    // Speed settings
    localparam logic [1:0] SPD_FULL = 2'h0;
    localparam logic [1:0] SPD_HALF = 2'h1;
    localparam logic [1:0] SPD_QUARTER = 2'h2;
    // Limits
    localparam int FAIL_LIMIT = 4;
    localparam int FRU_COUNT = 3;
    localparam int PHASE_COUNT = 14;
    localparam logic [3:0] PH_FIRST = 4'h1;
    localparam logic [3:0] PH_LAST = 4'he;
    // Hardware error code reported after the failure limit
    localparam logic [7:0] HW_ERR_CODE = 8'hf0;
    typedef enum {
        ST_IDLE,
        ST_ISSUE,
        ST_WAIT,
        ST_CALIB,
        ST_DONE,
        ST_HALT
    } fhs_state_t;
endpackage
`default_nettype wire

// [sim/fhs_motor_model.sv]
// Behavioural motor and sensor subsystem for the find home sequencer
`timescale 1ns/1ns
`default_nettype none
module fhs_motor_model
    import fhs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Command from sequencer
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_phase,
    // Fault injection from bench
    input wire logic [3:0] fail_phase,
    input wire logic [1:0] fail_kind,
    input wire logic [3:0] delay,
    // Answer to sequencer
    output logic mot_done,
    output logic mot_fault,
    output logic [1:0] mot_fault_kind
);
    logic [3:0] cnt;
    logic pend;
    logic bad;
    // One answer per command after a chosen delay
    always @(posedge mclk) begin
        mot_done <= 1'b0;
        mot_fault <= 1'b0;
        mot_fault_kind <= ~fail_kind; // Kind is junk outside a fault
        if (!nrst) begin
            pend <= 1'b0;
        end else if (cmd_valid) begin
            pend <= 1'b1;
            cnt <= delay;
            bad <= (cmd_phase == fail_phase);
        end else if (pend && cnt == 4'h0) begin
            pend <= 1'b0;
            mot_fault <= bad;
            mot_done <= !bad;
            if (bad) begin
                mot_fault_kind <= fail_kind;
            end
        end else if (pend) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking testbench for the find home sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import fhs_pkg::*;
    // ****************
    // Bench signals
    // ****************
    logic mclk = 1'b0;
    logic nrst, start, flip, cmd_valid, cmd_face, mot_done, mot_fault;
    logic fault_valid, busy, home_ok, calib_start, hw_error, once, hit;
    logic [3:0] lim, cmd_phase, fph, dly;
    logic [1:0] spd, cmd_speed, kind, fkind;
    logic [7:0] fault_code, hw_error_code;
    logic [2:0] fail_count;
    logic [23:0] fru_list;
    logic [6:0] cq[$];
    int miscompares = 0;
    int checks_done = 0;
    int ncal = 0;
    int nflt = 0;
    int q0, c0, f0;
    // Phase, kind and fault code of each injected fault
    localparam logic [15:0] FTAB [21] = '{16'h1040, 16'h2044, 16'h3045, 16'h4046,
        16'h5047, 16'h6041, 16'h6261, 16'h7045, 16'h8048, 16'h904d, 16'ha04a,
        16'ha14c, 16'ha260, 16'hb048, 16'hb14c, 16'hb260, 16'hc049, 16'hc14c,
        16'hc261, 16'hd049, 16'he14c};
    fhs_sequencer u_fhs_sequencer (.mclk(mclk), .nrst(nrst), .start(start),
        .retry_limit_setting(lim), .speed_setting(spd), .need_flip(flip),
        .cmd_valid(cmd_valid), .cmd_phase(cmd_phase), .cmd_face(cmd_face),
        .cmd_speed(cmd_speed), .mot_done(mot_done), .mot_fault(mot_fault),
        .mot_fault_kind(kind), .fault_valid(fault_valid), .fault_code(fault_code),
        .fail_count(fail_count), .busy(busy), .home_ok(home_ok),
        .calib_start(calib_start), .hw_error(hw_error),
        .hw_error_code(hw_error_code), .fru_list(fru_list));
    fhs_motor_model u_fhs_motor_model (.mclk(mclk), .nrst(nrst), .cmd_valid(cmd_valid),
        .cmd_phase(cmd_phase), .fail_phase(hit === 1'b1 ? 4'h0 : fph), .fail_kind(fkind),
        .delay(dly), .mot_done(mot_done), .mot_fault(mot_fault), .mot_fault_kind(kind));
    // Clock of 100 ns
    always #50 mclk = ~mclk;
    // Records commands, counts calibration starts and fault reports, masks one-shot faults
    always @(posedge mclk) begin
        if (cmd_valid === 1'b1) cq.push_back({cmd_speed, cmd_face, cmd_phase});
        if (calib_start === 1'b1) ncal++;
        if (fault_valid === 1'b1) nflt++;
        if (start === 1'b1) hit <= 1'b0;
        else if (mot_fault === 1'b1 && once) hit <= 1'b1;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One homing pass, waits for the sequencer to settle
    task automatic run(input logic [3:0] l, input logic [1:0] s, input logic f);
        int n = 0;
        q0 = cq.size();
        c0 = ncal;
        f0 = nflt;
        @(posedge mclk);
        start <= 1'b1;
        lim <= l;
        spd <= s;
        flip <= f;
        @(posedge mclk);
        start <= 1'b0;
        @(posedge mclk);
        while (busy !== 1'b0 && n < 3000) begin
            @(posedge mclk);
            n++;
        end
        repeat (2) @(posedge mclk);
        if (n >= 3000) begin
            miscompares++;
            $display("BAD %0t pass never ended", $time);
            print_verdict();
        end
    endtask
    task automatic t_clean(input logic [1:0] s, input logic f);
        logic [6:0] e[$];
        for (int p = 1; p <= 14; p++) begin
            if (p < 14 || f) e.push_back({s, 1'b0, 4'(p)});
            if (p == 11 || p == 12) e.push_back({s, 1'b1, 4'(p)});
        end
        fph <= 4'h0;
        dly <= 4'(s) * 4'h3;
        run(4'h4, s, f);
        chk(24'(cq.size() - q0), 24'(e.size()));
        for (int i = 0; i < e.size() && q0 + i < cq.size(); i++)
            chk(cq[q0 + i], e[i]);
        chk(home_ok, 1'b1);
        chk(24'(ncal - c0), 24'h1);
        chk(24'(nflt - f0), 24'h0);
        $display("t_clean done");
    endtask
    task automatic t_codes();
        dly <= 4'h1;
        foreach (FTAB[i]) begin
            fph <= FTAB[i][15:12];
            fkind <= FTAB[i][9:8];
            once <= 1'b1;
            run(4'h4, SPD_FULL, 1'b1);
            chk(fault_code, FTAB[i][7:0]);
            chk(home_ok, 1'b1);
            chk(fail_count, 3'h1);
            chk(24'(nflt - f0), 24'h1);
        end
        $display("t_codes done");
    endtask
    task automatic t_limit();
        fph <= 4'h3;
        fkind <= KIND_MOTION;
        once <= 1'b0;
        run(4'h4, SPD_FULL, 1'b1);
        chk(hw_error, 1'b1);
        chk(hw_error_code, HW_ERR_CODE);
        chk(fru_list, {3{FLT_FINGER_STOP}});
        chk(24'(nflt - f0), 24'h4);
        chk(fail_count, 3'h4);
        chk(home_ok, 1'b0);
        $display("t_limit done");
    endtask
    task automatic t_single();
        fph <= 4'h5;
        run(4'h1, SPD_FULL, 1'b1);
        chk(24'(cq.size() - q0), 24'h5);
        chk(24'(nflt - f0), 24'h1);
        chk(fault_code, 8'h47);
        chk({hw_error, home_ok}, 2'b00);
        $display("t_single done");
    endtask
    // Reset, then every scenario in turn
    initial begin
        {nrst, start, flip, once} = '0;
        {lim, spd, fph, fkind, dly} = '0;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        t_clean(SPD_FULL, 1'b1);
        t_clean(SPD_HALF, 1'b0);
        t_clean(SPD_QUARTER, 1'b1);
        t_codes();
        t_limit();
        t_single();
        print_verdict();
    end
endmodule
`default_nettype wire
